// ### core/rrs_host.sv
// controller end: register port, link master, events
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module rrs_host
    import rrs_pkg::*;
#(
    parameter int HALF_DIV = HALF_DIV_DEF
) (
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic EN,
    // register port
    input wire logic [REG_AW-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    // receiver strobes
    input wire logic CS_UPDATE_FLAG,
    input wire logic BURST_SYNC_OUT,
    // link
    rrs_link_if.host LINK
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_GAP = 4'b0100,
        ST_DATA = 4'b1000
    } rrs_state_t;

    typedef struct packed {
        rrs_state_t state;
        logic [2:0] ctrl;
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] mask;
        logic [7:0] div;
        logic [5:0] bcnt;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] word;
        logic [WORD_W-1:0] data;
        logic [1:0] dout_s;
        logic cs_p;
        logic pc_p;
        logic sclk;
        logic sel;
        logic din;
        logic irq;
        logic [31:0] rdata;
    } rrs_host_st_t;

    // refuse dividers that the receiver's sync lag or the 8-bit divider cannot serve
    if (HALF_DIV < 4 || HALF_DIV > 255) begin : g_bad_div
        $error("HALF_DIV out of range");
    end

    localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

    rrs_host_st_t st_q, st_d;
    logic tick, cs_fall, pc_fall, start;
    logic [EV_W-1:0] ev_set;
    logic [ADDR_W-1:0] start_addr;

    assign tick = (st_q.div == DIV_LAST);
    assign cs_fall = st_q.cs_p & ~CS_UPDATE_FLAG;
    assign pc_fall = st_q.pc_p & ~BURST_SYNC_OUT;

    // start sources, explicit write first
    always_comb begin
        start = 1'b0;
        start_addr = ADDR_CS;
        if (WR && ADDR == REG_CTRL && WDATA[CTRL_START]) begin
            start = 1'b1;
            start_addr = WDATA[CTRL_SEL_PC] ? ADDR_PC : ADDR_CS;
        end else if (st_q.ctrl[CTRL_AUTO_CS-1] && cs_fall) begin
            start = 1'b1;
        end else if (st_q.ctrl[CTRL_AUTO_PC-1] && pc_fall) begin
            start = 1'b1;
            start_addr = ADDR_PC;
        end
    end

    // next state
    always_comb begin
        st_d = st_q;
        ev_set = '0;
        ev_set[EV_CS_FALL] = cs_fall;
        ev_set[EV_PC_FALL] = pc_fall;
        st_d.cs_p = CS_UPDATE_FLAG;
        st_d.pc_p = BURST_SYNC_OUT;
        st_d.dout_s = {st_q.dout_s[0], LINK.dout};
        st_d.div = tick ? 8'h00 : st_q.div + 8'h01;
        case (st_q.state)
            ST_IDLE: begin
                st_d.div = 8'h00;
                if (start && st_q.state == ST_IDLE) begin
                    st_d.addr = start_addr;
                    st_d.din = start_addr[0];
                    st_d.bcnt = 6'h00;
                    st_d.state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                // address lsb first, receiver samples on rise
                if (tick) begin
                    st_d.sclk = ~st_q.sclk;
                    if (st_q.sclk) begin
                        st_d.bcnt = st_q.bcnt + 6'h01;
                        st_d.addr = {1'b0, st_q.addr[ADDR_W-1:1]};
                        st_d.din = st_q.addr[1];
                        if (st_q.bcnt == 6'(ADDR_W - 1)) begin
                            st_d.sel = 1'b1;
                            st_d.din = 1'b0;
                            st_d.bcnt = 6'h00;
                            st_d.state = ST_GAP;
                        end
                    end
                end
            end
            ST_GAP: begin
                // one link period for the receiver to load
                if (tick) begin
                    st_d.bcnt = st_q.bcnt + 6'h01;
                    if (st_q.bcnt[0]) begin
                        st_d.bcnt = 6'h00;
                        st_d.state = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                // sample slot at end of high phase
                if (tick) begin
                    st_d.sclk = ~st_q.sclk;
                    if (st_q.sclk) begin
                        st_d.word[st_q.bcnt] = st_q.dout_s[1];
                        st_d.bcnt = st_q.bcnt + 6'h01;
                        if (st_q.bcnt == 6'(WORD_W - 1)) begin
                            st_d.sel = 1'b0;
                            st_d.data = st_d.word;
                            ev_set[EV_DONE] = 1'b1;
                            st_d.state = ST_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_d.state = ST_IDLE;
                st_d.sclk = 1'b0;
                st_d.sel = 1'b0;
            end
        endcase
        // register writes, set wins over clear
        if (WR) begin
            case (ADDR)
                REG_CTRL: st_d.ctrl = WDATA[3:1];
                REG_IRQ_STAT: st_d.ev = st_q.ev & ~WDATA[EV_W-1:0];
                REG_IRQ_MASK: st_d.mask = WDATA[EV_W-1:0];
                default: st_d.mask = st_d.mask;
            endcase
        end
        st_d.ev = st_d.ev | ev_set;
        st_d.irq = |(st_d.ev & st_d.mask);
        // read data one cycle later, unmapped reads zero
        st_d.rdata = 32'h0;
        if (RD) begin
            case (ADDR)
                REG_CTRL: st_d.rdata = {28'h0, st_q.ctrl, 1'b0};
                REG_STATUS: st_d.rdata = {31'h0, st_q.state != ST_IDLE};
                REG_IRQ_STAT: st_d.rdata = {29'h0, st_q.ev};
                REG_IRQ_MASK: st_d.rdata = {29'h0, st_q.mask};
                REG_DATA_LO: st_d.rdata = st_q.data[31:0];
                REG_DATA_HI: st_d.rdata = {8'h0, st_q.data[WORD_W-1:32]};
                default: st_d.rdata = 32'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_q <= '0;
            st_q.state <= ST_IDLE;
            st_q.ctrl <= CTRL_RST;
            st_q.mask <= MASK_RST;
        end else if (EN) begin
            st_q <= st_d;
        end
    end

    assign RDATA = st_q.rdata;
    assign IRQ = st_q.irq;
    assign LINK.sclk = st_q.sclk;
    assign LINK.sel = st_q.sel;
    assign LINK.din = st_q.din;
endmodule : rrs_host

// ### core/rrs_pkg.sv
// constants shared by both ends of the status read-out link
//
// Contract
// - read address selects word, host clocks bits
// - host sends address e9 for status
// - slot 0 is channel-status update flag
// - slots 2,3 report delay state
// - slots 4-6 rate result, slot 7 zero
// - channel-status bit n in slot n+8
// - word frozen once address accepted
// - host reads on update-flag falling edge
// - channel-status field layout of 48 bits
// - host sends address ea for Pc
// - Pc msb first slots 0-15, rest zero
// - host reads on burst-sync falling edge
// - Pc field layout, type in bits 4-0
package rrs_pkg;
    // link word and read addresses
    localparam int WORD_W = 56;
    localparam int CS_W = 48;
    localparam int PC_W = 16;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CS = 8'he9;
    localparam logic [7:0] ADDR_PC = 8'hea;
    // slot positions of the channel-status word
    localparam int SLOT_FLAG = 0;
    localparam int SLOT_ERR = 1;
    localparam int SLOT_DLY = 2;
    localparam int SLOT_RATE = 4;
    localparam int SLOT_ZERO = 7;
    localparam int SLOT_CS = 8;
    // channel-status fields (bit position of each)
    localparam int CS_CATEGORY = 8;
    localparam int CS_SOURCE = 16;
    localparam int CS_CHANNEL = 20;
    localparam int CS_RATE = 24;
    localparam int CS_ACCURACY = 28;
    localparam int CS_WORDLEN = 32;
    // Pc fields
    localparam int PC_STREAM = 13;
    localparam int PC_DEPEND = 8;
    localparam int PC_ERROR = 7;
    localparam int PC_TYPE = 0;
    // link timing: half period of the link clock in ref cycles (4 -> 32 ns)
    localparam int REF_PERIOD_NS = 4;
    localparam int LINK_PERIOD_NS = 32;
    localparam int HALF_DIV_DEF = LINK_PERIOD_NS / (2 * REF_PERIOD_NS);
    // controller register map (word index on the plain port)
    localparam int REG_AW = 3;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_IRQ_STAT = 3'h2;
    localparam logic [2:0] REG_IRQ_MASK = 3'h3;
    localparam logic [2:0] REG_DATA_LO = 3'h4;
    localparam logic [2:0] REG_DATA_HI = 3'h5;
    // control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_SEL_PC = 1;
    localparam int CTRL_AUTO_CS = 2;
    localparam int CTRL_AUTO_PC = 3;
    // event bits
    localparam int EV_DONE = 0;
    localparam int EV_CS_FALL = 1;
    localparam int EV_PC_FALL = 2;
    localparam int EV_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
endpackage : rrs_pkg

// ### core/rrs_link_if.sv
// four-wire serial link between controller and receiver
`timescale 1ns/1ps
interface rrs_link_if;
    logic sclk; // link clock, made by the controller
    logic sel; // low: address phase, high: data phase
    logic din; // address bits to the receiver
    logic dout; // read bits from the receiver
    modport dev (input sclk, input sel, input din, output dout);
    modport host (output sclk, output sel, output din, input dout);
endinterface : rrs_link_if

// ### core/rrs_dev.sv
// receiver end: status word capture and serial read-out
`timescale 1ns/1ps
module rrs_dev
    import rrs_pkg::*;
(
    // clock, reset, enable
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic EN,
    // link
    rrs_link_if.dev LINK,
    // live pin levels
    input wire logic CS_UPDATE_FLAG,
    input wire logic ERROR_PIN,
    input wire logic DELAY_STATE_BIT0,
    input wire logic DELAY_STATE_BIT1,
    input wire logic RATE_RESULT_BIT0,
    input wire logic RATE_RESULT_BIT1,
    input wire logic RATE_RESULT_BIT2,
    // captured blocks
    input wire logic [CS_W-1:0] CHAN_STATUS,
    input wire logic [PC_W-1:0] PC_WORD,
    // state
    output logic READ_ACTIVE
);
    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] sel_s;
        logic [1:0] din_s;
        logic sclk_p;
        logic sel_p;
        logic [ADDR_W-1:0] addr;
        logic active;
        logic [WORD_W-1:0] shreg;
        logic dout;
    } rrs_dev_st_t;

    rrs_dev_st_t st_q, st_d;
    logic sclk_rise, sclk_fall, sel_rise, sel_fall;

    // status word in slot order, slot n at bit n
    function automatic logic [WORD_W-1:0] rrs_cs_word(
        input logic [6:0] pins,
        input logic [CS_W-1:0] cs
    );
        logic [WORD_W-1:0] w;
        w = '0;
        w[SLOT_FLAG +: 7] = pins;
        w[SLOT_ZERO] = 1'b0;
        w[SLOT_CS +: CS_W] = cs;
        return w;
    endfunction : rrs_cs_word

    // Pc word, msb in slot 0
    function automatic logic [WORD_W-1:0] rrs_pc_word(input logic [PC_W-1:0] pc);
        logic [WORD_W-1:0] w;
        w = '0;
        for (int i = 0; i < PC_W; i++) begin
            w[i] = pc[PC_W-1-i];
        end
        return w;
    endfunction : rrs_pc_word

    // edges seen on the second sync stage only
    assign sclk_rise = st_q.sclk_s[1] & ~st_q.sclk_p;
    assign sclk_fall = ~st_q.sclk_s[1] & st_q.sclk_p;
    assign sel_rise = st_q.sel_s[1] & ~st_q.sel_p;
    assign sel_fall = ~st_q.sel_s[1] & st_q.sel_p;

    // next state
    always_comb begin
        st_d = st_q;
        st_d.sclk_s = {st_q.sclk_s[0], LINK.sclk};
        st_d.sel_s = {st_q.sel_s[0], LINK.sel};
        st_d.din_s = {st_q.din_s[0], LINK.din};
        st_d.sclk_p = st_q.sclk_s[1];
        st_d.sel_p = st_q.sel_s[1];
        if (!st_q.sel_s[1] && sclk_rise) begin
            st_d.addr = {st_q.din_s[1], st_q.addr[ADDR_W-1:1]};
        end
        if (sel_rise) begin
            if (st_q.addr == ADDR_CS) begin
                st_d.shreg = rrs_cs_word({RATE_RESULT_BIT2, RATE_RESULT_BIT1, RATE_RESULT_BIT0,
                    DELAY_STATE_BIT1, DELAY_STATE_BIT0, ERROR_PIN, CS_UPDATE_FLAG}, CHAN_STATUS);
                st_d.active = 1'b1;
            end else if (st_q.addr == ADDR_PC) begin
                st_d.shreg = rrs_pc_word(PC_WORD);
                st_d.active = 1'b1;
            end else begin
                st_d.shreg = '0;
                st_d.active = 1'b0;
            end
            st_d.dout = st_d.shreg[0];
        end else if (sel_fall) begin
            st_d.active = 1'b0;
            st_d.dout = 1'b0;
        end else if (st_q.active && sclk_fall) begin
            st_d.shreg = {1'b0, st_q.shreg[WORD_W-1:1]};
            st_d.dout = st_q.shreg[1];
        end
    end

    // state register
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st_q <= '0;
        end else if (EN) begin
            st_q <= st_d;
        end
    end

    assign LINK.dout = st_q.dout;
    assign READ_ACTIVE = st_q.active;
endmodule : rrs_dev

// ### bench/rrs_link_asserts.sv
// link wire checks between controller and receiver
`timescale 1ns/1ps
module rrs_link_asserts
    import rrs_pkg::*;
#(
    parameter int HALF_DIV = HALF_DIV_DEF
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // link wires
    input wire logic sclk,
    input wire logic sel,
    input wire logic din,
    input wire logic dout
);
    logic sclk_q;
    logic sel_q;
    logic [5:0] pulse_q;
    logic [3:0] hi_q;
    logic [3:0] low_q;
    logic [7:0] addr_q;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    // pulse, phase and address trackers
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sclk_q <= 1'b0;
            sel_q <= 1'b0;
            pulse_q <= 6'h0;
            hi_q <= 4'h0;
            low_q <= 4'h0;
            addr_q <= 8'h0;
        end else begin
            sclk_q <= sclk;
            sel_q <= sel;
            hi_q <= sclk ? hi_q + 4'h1 : 4'h0;
            low_q <= (sel || low_q == 4'hf) ? (sel ? 4'h0 : low_q) : low_q + 4'h1;
            pulse_q <= (sel != sel_q) ? 6'h0 : pulse_q + 6'(sclk && !sclk_q);
            if (!sel && sclk && !sclk_q) begin
                addr_q <= {din, addr_q[7:1]};
            end
        end
    end
    // wire relations
    property p_reset_idle; disable iff (1'b0) RST |=> !sclk && !sel && !din && !dout; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
    property p_high_phase; $fell(sclk) |-> int'(hi_q) == HALF_DIV; endproperty
    a_high_phase: assert property (p_high_phase) else $error("link clock high phase wrong");
    property p_din_stable; sclk && $past(sclk) |-> $stable(din); endproperty
    a_din_stable: assert property (p_din_stable) else $error("address bit moved in high phase");
    property p_sel_quiet; $changed(sel) |-> $fell(sclk); endproperty
    a_sel_quiet: assert property (p_sel_quiet) else $error("phase change not on clock fall");
    property p_addr_count; $rose(sel) |-> pulse_q == 6'd8; endproperty
    a_addr_count: assert property (p_addr_count) else $error("address pulse count wrong");
    property p_addr_value; $rose(sel) |-> addr_q == ADDR_CS || addr_q == ADDR_PC; endproperty
    a_addr_value: assert property (p_addr_value) else $error("read address not e9 or ea");
    property p_gap; $rose(sel) |-> !sclk [*8]; endproperty
    a_gap: assert property (p_gap) else $error("no gap before data phase");
    property p_data_count; $fell(sel) |-> pulse_q == 6'd56; endproperty
    a_data_count: assert property (p_data_count) else $error("data pulse count wrong");
    property p_dout_idle; !sel && low_q > 4'h7 |-> !dout; endproperty
    a_dout_idle: assert property (p_dout_idle) else $error("read line busy outside frame");
endmodule : rrs_link_asserts

// ### bench/testbench.sv
// register level bench for controller and receiver ends
`timescale 1ns/1ps
module testbench;
    import rrs_pkg::*;
    // clock, reset and register port
    logic clk, rst, en, wr, rd, irq, bsync, ract;
    logic [2:0] addr;
    logic [31:0] wdata, rdata;
    // receiver inputs
    logic [6:0] pins;
    logic [CS_W-1:0] cs;
    logic [PC_W-1:0] pc;
    int n_errors = 0;
    int comparisons = 0;
    rrs_link_if rrs_link_if_inst ();
    rrs_host #(.HALF_DIV(4)) rrs_host_inst (.REF_CLK(clk), .RST(rst), .EN(en), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .CS_UPDATE_FLAG(pins[0]), .BURST_SYNC_OUT(bsync),
        .LINK(rrs_link_if_inst.host));
    rrs_dev rrs_dev_inst (.REF_CLK(clk), .RST(rst), .EN(en), .LINK(rrs_link_if_inst.dev),
        .CS_UPDATE_FLAG(pins[0]), .ERROR_PIN(pins[1]), .DELAY_STATE_BIT0(pins[2]), .DELAY_STATE_BIT1(pins[3]),
        .RATE_RESULT_BIT0(pins[4]), .RATE_RESULT_BIT1(pins[5]), .RATE_RESULT_BIT2(pins[6]),
        .CHAN_STATUS(cs), .PC_WORD(pc), .READ_ACTIVE(ract));
    rrs_link_asserts #(.HALF_DIV(4)) rrs_link_asserts_inst (.REF_CLK(clk), .RST(rst),
        .sclk(rrs_link_if_inst.sclk), .sel(rrs_link_if_inst.sel), .din(rrs_link_if_inst.din),
        .dout(rrs_link_if_inst.dout));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // verdict and end of run
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // compare tasks
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32
    task automatic chk1(input string nm, input logic e, input logic g);
        chk32(nm, {31'h0, e}, {31'h0, g});
    endtask : chk1
    // a wait that ran out ends the run
    task automatic bound_hit(input int n, input int lim);
        if (n >= lim) begin
            n_errors++;
            report_and_stop();
        end
    endtask : bound_hit
    // register port cycles
    task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    // one transfer: start, move inputs mid-frame, check word and events
    task automatic run(input logic [31:0] c, input int trig, input logic [31:0] st, input logic ir);
        logic [55:0] w;
        logic [31:0] d;
        int n;
        if (trig == 0) begin
            wr_reg(REG_CTRL, c | 32'h1);
        end else begin
            wr_reg(REG_CTRL, c);
            if (trig == 1) pins[0] <= 1'b0;
            else bsync <= 1'b0;
        end
        n = 0;
        while (ract !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        bound_hit(n, 300);
        w = {cs, 1'b0, pins};
        if (c[1] || trig == 2) begin
            w = '0;
            for (int k = 0; k < 16; k++) w[k] = pc[15-k];
        end
        @(posedge clk);
        cs <= ~cs;
        pc <= ~pc;
        pins <= pins ^ 7'h7e;
        d = 32'h1;
        n = 0;
        while (d[0] !== 1'b0 && n < 400) begin
            rd_reg(REG_STATUS, d);
            n++;
        end
        bound_hit(n, 400);
        rd_reg(REG_DATA_LO, d);
        chk32("data_lo", w[31:0], d);
        rd_reg(REG_DATA_HI, d);
        chk32("data_hi", {8'h00, w[55:32]}, d);
        rd_reg(REG_IRQ_STAT, d);
        chk32("irq_stat", st, d);
        chk1("irq", ir, irq);
        wr_reg(REG_IRQ_STAT, 32'h7);
        rd_reg(REG_IRQ_STAT, d);
        chk32("irq_stat_clr", 32'h0, d);
        chk1("irq_clr", 1'b0, irq);
        $display("test done ctrl %h", c);
    endtask : run
    // main sequence
    initial begin
        logic [31:0] d;
        rst = 1'b1;
        en = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 32'h0;
        pins = 7'h35;
        cs = 48'h9a3c_5e71_0f2b;
        pc = 16'hb4d1;
        bsync = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped words read zero
        for (int a = 0; a < 8; a++) begin
            rd_reg(3'(a), d);
            chk32("reset_word", 32'h0, d);
        end
        chk1("irq_reset", 1'b0, irq);
        wr_reg(REG_IRQ_MASK, 32'h7);
        wr_reg(3'h6, 32'hffff_ffff);
        rd_reg(3'h6, d);
        chk32("unmapped", 32'h0, d);
        rd_reg(REG_IRQ_MASK, d);
        chk32("irq_mask", 32'h7, d);
        // a write while the enable is low must be lost
        en <= 1'b0;
        wr_reg(REG_IRQ_MASK, 32'h0);
        en <= 1'b1;
        rd_reg(REG_IRQ_MASK, d);
        chk32("mask_frozen", 32'h7, d);
        $display("test done reset and register map");
        run(32'h0, 0, 32'h1, 1'b1);
        run(32'h2, 0, 32'h1, 1'b1);
        rd_reg(REG_CTRL, d);
        chk32("ctrl", 32'h2, d);
        run(32'h4, 1, 32'h3, 1'b1);
        wr_reg(REG_IRQ_MASK, 32'h2);
        run(32'h8, 2, 32'h5, 1'b0);
        report_and_stop();
    end
endmodule : testbench
